// file: inc/link_ctrl_map.vh
// Constants for the transmit link control block
`ifndef LINK_CTRL_MAP_VH
`define LINK_CTRL_MAP_VH
// ==========================================
// Line coding and lane limits
`define ENC_8B10B      1'b0
`define ENC_64B66B     1'b1
`define MAX_LANES      16
// ==========================================
// Control characters (8-bit values, sent with the k flag)
`define K28_5          8'hBC
`define K28_0          8'h1C
`define K28_3          8'h7C
// ==========================================
// Alignment sequence and multiframe defaults
`define ILAS_MFRAMES   3'h4
`define DEF_F          9'h001
`define DEF_K          9'h020
// ==========================================
// 64B/66B sync headers
`define SH_DATA        2'h1
`define SH_CTRL        2'h2
`endif

// file: logic/sync_2ff.v
// Two flip-flop synchroniser for one level signal
`default_nettype none
module sync_2ff (
  input  wire clk_i,
  input  wire rst_n_i,
  input  wire d_i,
  output wire q_o
);
  reg meta_reg;
  reg sync_reg;
  // ==========================================
  // Synchroniser; first stage feeds only the second
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta_reg <= 1'b0;
      sync_reg <= 1'b0;
    end else begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
    end
  end
  assign q_o = sync_reg;
endmodule
`default_nettype wire

// file: logic/frame_clock_counter.v
// Multiframe / extended multiblock clock counter reset by SYSREF
`default_nettype none
module frame_clock_counter #(
  parameter W = 18
) (
  input  wire         clk_i,
  input  wire         rst_n_i,
  input  wire         sysref_edge_i,
  input  wire [W-1:0] period_i,
  output wire         edge_o,
  output wire [W-1:0] count_o
);
  reg  [W-1:0] cnt_reg;
  wire [W-1:0] last = period_i - {{(W-1){1'b0}}, 1'b1};
  // ==========================================
  // Counter; SYSREF forces a deterministic phase of zero
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      cnt_reg <= {W{1'b0}};
    end else if (sysref_edge_i) begin
      cnt_reg <= {W{1'b0}};
    end else if (cnt_reg >= last) begin
      cnt_reg <= {W{1'b0}};
    end else begin
      cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
    end
  end
  assign edge_o  = (cnt_reg == {W{1'b0}});
  assign count_o = cnt_reg;
endmodule
`default_nettype wire

// file: logic/tx_link_control.v
// Transmit link control: line coding, SYNC handshake, SYSREF, ILAS
`include "link_ctrl_map.vh"
`default_nettype none
module tx_link_control #(
  parameter LANES = `MAX_LANES,
  parameter CW    = 18
) (
  input  wire                 clk_i,
  input  wire                 rst_n_i,
  input  wire                 enc_mode_i,
  input  wire [4:0]           lanes_used_i,
  input  wire [8:0]           f_octets_i,
  input  wire [8:0]           k_frames_i,
  input  wire                 scr_en_i,
  input  wire                 fec_en_i,
  input  wire                 nco_sync_sel_i,
  input  wire                 sync_n_i,
  input  wire                 sysref_i,
  input  wire [8*LANES-1:0]   tx_octets_i,
  output reg  [8*LANES-1:0]   lane_octets_o,
  output reg  [LANES-1:0]     lane_is_k_o,
  output reg  [LANES-1:0]     lane_en_o,
  output reg  [1:0]           sync_header_o,
  output reg                  scramble_o,
  output reg                  fec_o,
  output reg                  crc3_o,
  output reg                  cmd_chan_o,
  output reg                  nco_sync_o,
  output reg                  link_up_o,
  output reg                  lmfc_edge_o,
  output wire                 data_ready_o
);
  // ==========================================
  // States
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_CGS  = 4'b0010;
  localparam [3:0] ST_WAIT = 4'b0100;
  localparam [3:0] ST_ILAS = 4'b1000;

  // ==========================================
  // Synchronised inputs
  wire sync_n_s;
  wire sysref_s;
  reg  sync_d_reg;
  reg  sysref_d_reg;
  // Request sense is synchronised so reset leaves SYNC at its idle high level
  wire sync_req_s;
  assign sync_n_s = ~sync_req_s;
  sync_2ff u_sync_sync (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(~sync_n_i), .q_o(sync_req_s));
  sync_2ff u_sync_sysref (.clk_i(clk_i), .rst_n_i(rst_n_i), .d_i(sysref_i), .q_o(sysref_s));
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync_d_reg   <= 1'b1;
      sysref_d_reg <= 1'b0;
    end else begin
      sync_d_reg   <= sync_n_s;
      sysref_d_reg <= sysref_s;
    end
  end
  wire sysref_edge = sysref_s & ~sysref_d_reg;
  wire sync_rise   = sync_n_s & ~sync_d_reg; // Level sampled, so any 204A/B pulse width works

  // ==========================================
  // Multiframe clock: one count per octet, F*K octets per multiframe
  // In 8B/10B each octet is 10 bits on the line, giving 10*F*K bit periods
  wire [CW-1:0] period = f_octets_i * k_frames_i;
  wire          lmfc_edge;
  wire [CW-1:0] lmfc_cnt;
  frame_clock_counter #(.W(CW)) u_lmfc (
    .clk_i         (clk_i),
    .rst_n_i       (rst_n_i),
    .sysref_edge_i (sysref_edge),
    .period_i      ((period == {CW{1'b0}}) ? {{(CW-1){1'b0}}, 1'b1} : period),
    .edge_o        (lmfc_edge),
    .count_o       (lmfc_cnt)
  );
  wire mf_last = (lmfc_cnt == period - {{(CW-1){1'b0}}, 1'b1});

  // ==========================================
  // Link state machine (8B/10B handshake)
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [2:0] mf_reg;
  reg [2:0] mf_next;
  wire      mode8 = (enc_mode_i == `ENC_8B10B);

  always @* begin
    state_next = state_reg;
    mf_next    = mf_reg;
    case (state_reg)
      ST_IDLE: begin
        if (!mode8) begin
          state_next = ST_IDLE; // Header-based block sync, SYNC only drives nco_sync_o
        end else if (!sync_n_s) begin
          state_next = ST_CGS;
        end
      end
      ST_CGS: begin
        if (sync_rise) begin
          state_next = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (!sync_n_s) begin
          state_next = ST_CGS;
        end else if (mf_last) begin
          state_next = ST_ILAS; // Next count is the LMFC edge, so ILAS opens on it
          mf_next    = 3'h0;
        end
      end
      ST_ILAS: begin
        if (!sync_n_s) begin
          state_next = ST_CGS;
        end else if (mf_last) begin
          mf_next = mf_reg + 3'h1;
          if (mf_reg == `ILAS_MFRAMES - 3'h1) begin
            state_next = ST_IDLE; // Four multiframes done
          end
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    if (!mode8) begin
      state_next = ST_IDLE;
    end
  end

  reg data_phase_reg;
  reg mode8_d_reg;
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      state_reg      <= ST_IDLE;
      mf_reg         <= 3'h0;
      data_phase_reg <= 1'b0;
      mode8_d_reg    <= 1'b0;
    end else begin
      state_reg   <= state_next;
      mf_reg      <= mf_next;
      mode8_d_reg <= mode8;
      if (!mode8) begin
        data_phase_reg <= 1'b1;
      end else if (!mode8_d_reg) begin
        data_phase_reg <= 1'b0; // Entering 8B/10B needs a fresh handshake
      end else if (state_reg == ST_ILAS && state_next == ST_IDLE) begin
        data_phase_reg <= 1'b1;
      end else if (state_next != ST_IDLE) begin
        data_phase_reg <= 1'b0;
      end
    end
  end
  assign data_ready_o = data_phase_reg & (state_reg == ST_IDLE);

  // ==========================================
  // Per-lane character selection; all lanes share one state so they align
  // Only a single-link alignment exists; no MULTIREF input
  genvar g;
  generate
    for (g = 0; g < LANES; g = g + 1) begin : g_lane
      wire       used = (g < lanes_used_i) && (g < `MAX_LANES);
      reg  [7:0] oct;
      reg        kf;
      always @* begin
        oct = tx_octets_i[8*g +: 8];
        kf  = 1'b0;
        if (mode8 && state_reg != ST_IDLE) begin
          kf = 1'b1;
          if (state_reg == ST_ILAS && lmfc_edge) begin
            oct = `K28_0; // Multiframe start
          end else if (state_reg == ST_ILAS && mf_last) begin
            oct = `K28_3; // Multiframe end
          end else if (state_reg == ST_ILAS) begin
            oct = 8'h00; // ILAS body, not scrambled
            kf  = 1'b0;
          end else begin
            oct = `K28_5; // Comma stream while SYNC low or waiting
          end
        end else if (!data_phase_reg) begin
          oct = 8'h00;
        end
      end
      always @(posedge clk_i) begin
        if (!rst_n_i) begin
          lane_octets_o[8*g +: 8] <= 8'h00;
          lane_is_k_o[g]          <= 1'b0;
          lane_en_o[g]            <= 1'b0;
        end else begin
          lane_octets_o[8*g +: 8] <= oct;
          lane_is_k_o[g]          <= kf;
          lane_en_o[g]            <= used;
        end
      end
    end
  endgenerate

  // ==========================================
  // Link options: mode-dependent, with CRC-3 and command channel held off in both modes
  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      sync_header_o <= 2'h0;
      scramble_o    <= 1'b0;
      fec_o         <= 1'b0;
      crc3_o        <= 1'b0;
      cmd_chan_o    <= 1'b0;
      nco_sync_o    <= 1'b0;
      link_up_o     <= 1'b0;
      lmfc_edge_o   <= 1'b0;
    end else begin
      sync_header_o <= mode8 ? 2'h0 : `SH_DATA;
      scramble_o    <= mode8 ? (scr_en_i & data_phase_reg & (state_reg == ST_IDLE)) : 1'b1;
      fec_o         <= ~mode8 & fec_en_i;
      crc3_o        <= 1'b0;
      cmd_chan_o    <= 1'b0;
      nco_sync_o    <= ~mode8 & nco_sync_sel_i & ~sync_n_s;
      link_up_o     <= data_ready_o; // 8B/10B stream stays 204B-legal
      lmfc_edge_o   <= lmfc_edge; // Everything here runs on clk_i
    end
  end
endmodule
`default_nettype wire

// file: test/link_props_properties.sv
// Port assertions for the transmit link control block
`default_nettype none
module link_props #(
  parameter LANES = 16
) (
  input wire logic               clk_i,
  input wire logic               rst_n_i,
  input wire logic               enc_mode_i,
  input wire logic [4:0]         lanes_used_i,
  input wire logic               fec_en_i,
  input wire logic               nco_sync_sel_i,
  input wire logic               sync_n_i,
  input wire logic               sysref_i,
  input wire logic [8*LANES-1:0] lane_octets_o,
  input wire logic [LANES-1:0]   lane_is_k_o,
  input wire logic [LANES-1:0]   lane_en_o,
  input wire logic [1:0]         sync_header_o,
  input wire logic               scramble_o,
  input wire logic               fec_o,
  input wire logic               crc3_o,
  input wire logic               cmd_chan_o,
  input wire logic               nco_sync_o,
  input wire logic               lmfc_edge_o,
  input wire logic               link_up_o,
  input wire logic               data_ready_o
);
  // ==========
  // Helper
  logic [LANES-1:0] en_exp;
  always_comb for (int g = 0; g < LANES; g++) en_exp[g] = (g < lanes_used_i);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========
  // Properties
  crc_off_a: assert property (!crc3_o) else $error("crc3 active");
  cmd_off_a: assert property (!cmd_chan_o) else $error("command channel active");
  hdr_mode_a: assert property ($past(rst_n_i) |-> sync_header_o == ($past(enc_mode_i) ? 2'h1 : 2'h0))
    else $error("sync header wrong");
  scr_long_a: assert property ($past(rst_n_i) && $past(enc_mode_i) |-> scramble_o)
    else $error("scrambler off in 64b66b");
  k_unscr_a: assert property (lane_is_k_o[0] |-> !scramble_o) else $error("control char scrambled");
  fec_mode_a: assert property ($past(rst_n_i) |-> fec_o == ($past(enc_mode_i) && $past(fec_en_i)))
    else $error("fec wrong");
  lane_en_a: assert property ($past(rst_n_i) |-> lane_en_o == $past(en_exp))
    else $error("lane enables wrong");
  comma_out_a: assert property ((!enc_mode_i && !sync_n_i) [*5] |-> lane_is_k_o[0] && lane_octets_o[7:0] == 8'hBC)
    else $error("no comma while sync low");
  nco_sync_a: assert property ((enc_mode_i && nco_sync_sel_i && !sync_n_i) [*5] |-> nco_sync_o)
    else $error("nco sync missing");
  no_k_long_a: assert property (enc_mode_i && $past(enc_mode_i) && $past(rst_n_i) |-> lane_is_k_o == '0)
    else $error("control char in 64b66b");
  sysref_lmfc_a: assert property ($rose(sysref_i) |-> ##[1:6] lmfc_edge_o)
    else $error("no lmfc edge after sysref");
  link_up_a: assert property ($past(rst_n_i) |-> link_up_o == $past(data_ready_o))
    else $error("link up does not follow data ready");
endmodule

bind tx_link_control link_props #(.LANES(LANES)) chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .enc_mode_i(enc_mode_i), .lanes_used_i(lanes_used_i),
  .fec_en_i(fec_en_i), .nco_sync_sel_i(nco_sync_sel_i), .sync_n_i(sync_n_i), .sysref_i(sysref_i),
  .lane_octets_o(lane_octets_o), .lane_is_k_o(lane_is_k_o), .lane_en_o(lane_en_o),
  .sync_header_o(sync_header_o), .scramble_o(scramble_o), .fec_o(fec_o), .crc3_o(crc3_o),
  .cmd_chan_o(cmd_chan_o), .nco_sync_o(nco_sync_o), .lmfc_edge_o(lmfc_edge_o),
  .link_up_o(link_up_o), .data_ready_o(data_ready_o)
);
`default_nettype wire

// file: test/rx_model.sv
// Receiver model driving the link handshake
`default_nettype none
module rx_model (
  input  wire logic       clk_i,
  input  wire logic       start_i,
  input  wire logic [7:0] oct_i,
  input  wire logic       is_k_i,
  input  wire logic       lmfc_i,
  output var  logic       sync_n_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  initial sync_n_o = 1'b1;
  // Releases only on an LMFC edge, so a slow release is the normal case
  always @(posedge clk_i) begin
    if (!start_i) cnt <= 0;
    else if (is_k_i && oct_i == 8'hBC) cnt <= cnt + 1;
    if (start_i && cnt == 0) sync_n_o <= #1 1'b0;
    else if (cnt >= 4 && lmfc_i) sync_n_o <= #1 1'b1;
  end
endmodule
`default_nettype wire

// file: test/tx_link_control_test.sv
// Self-checking bench for the transmit link control
`default_nettype none
module tx_link_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_i = 0, rst_n_i = 0, enc = 1, scr = 1, fec = 1, sref = 0, start = 0, sync_tb = 1;
  logic [4:0]  lanes = 5'h04;
  logic [31:0] data = 32'h0, seed = 32'hDC22F6FA;
  logic [31:0] oct;
  logic [3:0]  is_k;
  logic        rx_sync, rdy, lmfc, scr_o;
  int          err_count = 0, total_checks = 0, nr = 0, na = 0;
  logic [31:0] q[$];
  wire logic   sync_n = enc ? sync_tb : rx_sync;
  tx_link_control #(.LANES(4)) uut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .enc_mode_i(enc), .lanes_used_i(lanes), .f_octets_i(9'h002),
    .k_frames_i(9'h004), .scr_en_i(scr), .fec_en_i(fec), .nco_sync_sel_i(1'b1), .sync_n_i(sync_n),
    .sysref_i(sref), .tx_octets_i(data), .lane_octets_o(oct), .lane_is_k_o(is_k), .lane_en_o(),
    .sync_header_o(), .scramble_o(scr_o), .fec_o(), .crc3_o(), .cmd_chan_o(), .nco_sync_o(),
    .link_up_o(), .lmfc_edge_o(lmfc), .data_ready_o(rdy));
  rx_model rx (.clk_i(clk_i), .start_i(start), .oct_i(oct[7:0]), .is_k_i(is_k[0]), .lmfc_i(lmfc),
    .sync_n_o(rx_sync));
  always #4 clk_i = ~clk_i;
  // ==========
  // Tasks
  task check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task summarize;
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task stream(input int n);
    repeat (n) begin
      @(posedge clk_i) #1 data = $random(seed);
      q.push_back(data);
    end
  endtask
  // ==========
  // Monitor: settled half a step after the edge, before the next drive
  always @(posedge clk_i) begin
    #0.5;
    if (is_k[0] && oct[7:0] == 8'h1C) nr++;
    if (is_k[0] && oct[7:0] == 8'h7C) na++;
    if (q.size() > 0) check(oct, q.pop_front());
  end
  initial begin
    repeat (3000) @(posedge clk_i);
    err_count++;
    summarize;
  end
  // ==========
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_i);
    #1 rst_n_i = 1;
    stream(12);
    sync_tb = 0;
    stream(8);
    sref = 1;
    lanes = 5'({$random(seed)} % 16 + 1);
    stream(2);
    sref = 0;
    sync_tb = 1;
    fec = 0;
    stream(8);
    repeat (2) @(posedge clk_i);
    #1 enc = 0;
    start = 1;
    repeat (2) @(posedge clk_i);
    for (int i = 0; i < 600 && rdy !== 1'b1; i++) @(posedge clk_i);
    repeat (2) @(posedge clk_i);
    #1 check(nr, 4);
    check(na, 4);
    check(scr_o, 1);
    stream(12);
    repeat (2) @(posedge clk_i);
    summarize;
  end
endmodule
`default_nettype wire
